// ==== sxsf_defines.svh ====
// Register indices, field positions and reset values of the serial port status block
`ifndef SXSF_DEFINES_SVH
`define SXSF_DEFINES_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define SXSF_IDX_422_STAT   10'h13e
`define SXSF_IDX_422_CNT    10'h13f
`define SXSF_IDX_232_STAT   10'h188
`define SXSF_IDX_232_CNT    10'h189
`define SXSF_IDX_232_TLINK  10'h18a
`define SXSF_IDX_CTRL       10'h1a0
`define SXSF_IDX_CMD        10'h1a1
`define SXSF_IDX_IRQ_STAT   10'h1a2
`define SXSF_IDX_IRQ_MASK   10'h1a3

// ============================================================
// RS-422A status word fields
`define SXSF_B422_PARITY    2
`define SXSF_B422_FRAMING   3
`define SXSF_B422_OVERRUN   4
`define SXSF_B422_TIMEOUT   5
`define SXSF_B422_COMM_ERR  8
`define SXSF_B422_SEND_RDY  9
`define SXSF_B422_RX_DONE   10
`define SXSF_B422_RX_OVF    11
`define SXSF_B422_CFG_BUSY  15

// ============================================================
// RS-232C status word fields
`define SXSF_B232_COMM_ERR  4
`define SXSF_B232_SEND_RDY  5
`define SXSF_B232_RX_DONE   6
`define SXSF_B232_RX_OVF    7
`define SXSF_B232_CFG_BUSY  12

// ============================================================
// Control, command and interrupt fields
`define SXSF_CTRL_422_EN    0
`define SXSF_CTRL_232_EN    1
`define SXSF_CMD_422_RST    0
`define SXSF_CMD_232_RST    1
`define SXSF_IRQ_422_DONE   0
`define SXSF_IRQ_422_OVF    1
`define SXSF_IRQ_422_ERR    2
`define SXSF_IRQ_232_DONE   3
`define SXSF_IRQ_232_OVF    4
`define SXSF_IRQ_232_ERR    5
`define SXSF_IRQ_W          6

// ============================================================
// Reset values
`define SXSF_RST_CTRL       2'h0
`define SXSF_RST_MASK       6'h00
`define SXSF_RST_CNT        16'h0000

`endif

// ==== sxsf_pkg.sv ====
// Types shared by the serial port status block
package sxsf_pkg;

    // Events and levels from one serial port engine
    typedef struct packed {
        logic       rx_byte;
        logic       rx_done;
        logic       rx_ovf;
        logic [3:0] err;
        logic       tx_ready;
        logic       cfg_busy;
    } sxsf_port_ev_t;

    // Status seen by software for one port
    typedef struct packed {
        logic [3:0] err;
        logic       comm_err;
        logic       send_rdy;
        logic       rx_done;
        logic       rx_ovf;
        logic       cfg_busy;
    } sxsf_port_flags_t;

endpackage

// ==== sxsf_port.sv ====
// Per-port status flags and reception byte counter
`timescale 1ns/1ps
`include "sxsf_defines.svh"

module sxsf_port
    import sxsf_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             nopro_en,
    input  wire logic             restart,
    input  wire sxsf_port_ev_t    ev,
    output sxsf_port_flags_t      flags,
    output logic [CNT_W-1:0]      count
);

    initial begin
        if (CNT_W < 2 || CNT_W > 32) begin
            $error("sxsf_port: CNT_W out of range");
        end
    end

    // ============================================================
    // Sticky flags: a set in the same cycle as a restart wins
    wire             byte_hit  = ev.rx_byte & nopro_en;
    wire             done_hit  = ev.rx_done & nopro_en;
    wire             ovf_hit   = ev.rx_ovf & nopro_en;
    wire             any_err   = |ev.err;
    wire [3:0]       err_d     = (flags.err & {4{~restart}}) | ev.err;
    wire             comm_d    = (flags.comm_err & ~restart) | any_err;
    wire             done_d    = (flags.rx_done & ~restart) | done_hit;
    wire             ovf_d     = (flags.rx_ovf & ~restart) | ovf_hit;
    // Counter moves with each byte so it is final when done sets
    wire [CNT_W-1:0] cnt_inc   = count + {{(CNT_W-1){1'b0}}, 1'b1};
    wire [CNT_W-1:0] cnt_base  = restart ? '0 : count;
    wire [CNT_W-1:0] cnt_bump  = restart ? {{(CNT_W-1){1'b0}}, 1'b1} : cnt_inc;
    wire [CNT_W-1:0] count_d   = byte_hit ? cnt_bump : cnt_base;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
            count <= '0;
        end else begin
            flags.err      <= err_d;
            flags.comm_err <= comm_d;
            flags.rx_done  <= done_d;
            flags.rx_ovf   <= ovf_d;
            flags.send_rdy <= ev.tx_ready & nopro_en;
            flags.cfg_busy <= ev.cfg_busy;
            count          <= count_d;
        end
    end

endmodule

// ==== sxsf_top.sv ====
// Serial port status flags, reception counters and terminal link flags behind APB
//
// Overview of operation
// - RS-422A reception-completed bit sets when a no-protocol reception finishes.
// - RS-422A overflow bit sets when no-protocol reception data overflows.
// - RS-422A settings-changing bit high only while port settings change.
// - RS-422A 16-bit binary count of no-protocol bytes received, readable.
// - RS-232C communications-error bit sets on any port communication error.
// - RS-232C send-ready bit high while no-protocol port can accept data.
// - RS-232C reception-completed bit sets when a no-protocol reception finishes.
// - RS-232C overflow bit sets when no-protocol reception data overflows.
// - RS-232C settings-changing bit high only while port settings change.
// - RS-232C 16-bit binary count of no-protocol bytes received, readable.
// - Eight bits show which operator terminal units the RS-232C port serves.
// - Upper byte bits show which operator terminal unit holds priority.
// - RS-422A separate parity, framing, overrun and timeout error bits.
// - RS-422A communications-error bit sets on any port communication error.
// - RS-422A send-ready bit high while no-protocol port can accept data.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "sxsf_defines.svh"

module sxsf_top
    import sxsf_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    input  wire sxsf_port_ev_t    ev_422,
    input  wire sxsf_port_ev_t    ev_232,
    input  wire logic [7:0]       operator_terminal_comm,
    input  wire logic [7:0]       operator_terminal_prio,
    output logic                  irq
);

    initial begin
        if (CNT_W != 16) begin
            $error("sxsf_top: reception counters are 16 bits wide");
        end
    end

    // ============================================================
    // APB decode
    wire [9:0]  idx        = paddr[11:2];
    wire        aligned    = (paddr[1:0] == 2'b00);
    wire        setup      = psel & ~penable;
    wire        access     = psel & penable;
    wire        hit_422s   = aligned && (idx == `SXSF_IDX_422_STAT);
    wire        hit_422c   = aligned && (idx == `SXSF_IDX_422_CNT);
    wire        hit_232s   = aligned && (idx == `SXSF_IDX_232_STAT);
    wire        hit_232c   = aligned && (idx == `SXSF_IDX_232_CNT);
    wire        hit_tlink  = aligned && (idx == `SXSF_IDX_232_TLINK);
    wire        hit_ctrl   = aligned && (idx == `SXSF_IDX_CTRL);
    wire        hit_cmd    = aligned && (idx == `SXSF_IDX_CMD);
    wire        hit_istat  = aligned && (idx == `SXSF_IDX_IRQ_STAT);
    wire        hit_imask  = aligned && (idx == `SXSF_IDX_IRQ_MASK);
    wire        hit_any    = hit_422s | hit_422c | hit_232s | hit_232c | hit_tlink |
                             hit_ctrl | hit_cmd | hit_istat | hit_imask;
    // Writes take effect at the access edge only; status words ignore writes
    wire        wr_en      = access & pwrite & pstrb[0];
    wire        wr_ctrl    = wr_en & hit_ctrl;
    wire        wr_cmd     = wr_en & hit_cmd;
    wire        wr_istat   = wr_en & hit_istat;
    wire        wr_imask   = wr_en & hit_imask;

    // ============================================================
    // Control and command
    logic [1:0]              ctrl_q;
    logic [`SXSF_IRQ_W-1:0]  imask_q;
    logic [`SXSF_IRQ_W-1:0]  istat_q;
    logic [7:0]              tl_comm_q;
    logic [7:0]              tl_prio_q;

    wire        en_422     = ctrl_q[`SXSF_CTRL_422_EN];
    wire        en_232     = ctrl_q[`SXSF_CTRL_232_EN];
    wire        rst_422    = wr_cmd & pwdata[`SXSF_CMD_422_RST];
    wire        rst_232    = wr_cmd & pwdata[`SXSF_CMD_232_RST];

    // ============================================================
    // Port engines
    sxsf_port_flags_t        fl_422;
    sxsf_port_flags_t        fl_232;
    logic [CNT_W-1:0]        cnt_422;
    logic [CNT_W-1:0]        cnt_232;

    sxsf_port #(
        .CNT_W   (CNT_W)
    ) u_port_422 (
        .pclk     (pclk),
        .presetn  (presetn),
        .nopro_en (en_422),
        .restart  (rst_422),
        .ev       (ev_422),
        .flags    (fl_422),
        .count    (cnt_422)
    );

    sxsf_port #(
        .CNT_W   (CNT_W)
    ) u_port_232 (
        .pclk     (pclk),
        .presetn  (presetn),
        .nopro_en (en_232),
        .restart  (rst_232),
        .ev       (ev_232),
        .flags    (fl_232),
        .count    (cnt_232)
    );

    // ============================================================
    // Status words
    logic [15:0] stat_422;
    logic [15:0] stat_232;

    always_comb begin
        stat_422 = 16'h0000;
        stat_422[`SXSF_B422_PARITY]   = fl_422.err[0];
        stat_422[`SXSF_B422_FRAMING]  = fl_422.err[1];
        stat_422[`SXSF_B422_OVERRUN]  = fl_422.err[2];
        stat_422[`SXSF_B422_TIMEOUT]  = fl_422.err[3];
        stat_422[`SXSF_B422_COMM_ERR] = fl_422.comm_err;
        stat_422[`SXSF_B422_SEND_RDY] = fl_422.send_rdy;
        stat_422[`SXSF_B422_RX_DONE]  = fl_422.rx_done;
        stat_422[`SXSF_B422_RX_OVF]   = fl_422.rx_ovf;
        stat_422[`SXSF_B422_CFG_BUSY] = fl_422.cfg_busy;
    end

    always_comb begin
        stat_232 = 16'h0000;
        stat_232[`SXSF_B232_COMM_ERR] = fl_232.comm_err;
        stat_232[`SXSF_B232_SEND_RDY] = fl_232.send_rdy;
        stat_232[`SXSF_B232_RX_DONE]  = fl_232.rx_done;
        stat_232[`SXSF_B232_RX_OVF]   = fl_232.rx_ovf;
        stat_232[`SXSF_B232_CFG_BUSY] = fl_232.cfg_busy;
    end

    // Unit bits in low byte, priority holder in high byte
    wire [15:0] tlink_word = {tl_prio_q, tl_comm_q};

    // ============================================================
    // Interrupt events: rising edges of the sticky port flags
    logic [`SXSF_IRQ_W-1:0]  src_q;
    logic [`SXSF_IRQ_W-1:0]  src_now;

    always_comb begin
        src_now = '0;
        src_now[`SXSF_IRQ_422_DONE] = fl_422.rx_done;
        src_now[`SXSF_IRQ_422_OVF]  = fl_422.rx_ovf;
        src_now[`SXSF_IRQ_422_ERR]  = fl_422.comm_err;
        src_now[`SXSF_IRQ_232_DONE] = fl_232.rx_done;
        src_now[`SXSF_IRQ_232_OVF]  = fl_232.rx_ovf;
        src_now[`SXSF_IRQ_232_ERR]  = fl_232.comm_err;
    end

    wire [`SXSF_IRQ_W-1:0] irq_set   = src_now & ~src_q;
    wire [`SXSF_IRQ_W-1:0] irq_clr   = wr_istat ? pwdata[`SXSF_IRQ_W-1:0] : '0;
    // New event beats a write-one-to-clear in the same cycle
    wire [`SXSF_IRQ_W-1:0] istat_d   = (istat_q & ~irq_clr) | irq_set;

    assign irq = |(istat_q & imask_q);

    // ============================================================
    // Read mux, sampled at setup so data is ready in the access phase
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_422s) begin
            rd_mux[15:0] = stat_422;
        end else if (hit_422c) begin
            rd_mux[15:0] = cnt_422;
        end else if (hit_232s) begin
            rd_mux[15:0] = stat_232;
        end else if (hit_232c) begin
            rd_mux[15:0] = cnt_232;
        end else if (hit_tlink) begin
            rd_mux[15:0] = tlink_word;
        end else if (hit_ctrl) begin
            rd_mux[1:0] = ctrl_q;
        end else if (hit_istat) begin
            rd_mux[`SXSF_IRQ_W-1:0] = istat_q;
        end else if (hit_imask) begin
            rd_mux[`SXSF_IRQ_W-1:0] = imask_q;
        end
    end

    assign pready = 1'b1;

    // ============================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~hit_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= `SXSF_RST_CTRL;
            imask_q <= `SXSF_RST_MASK;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[1:0];
            end
            if (wr_imask) begin
                imask_q <= pwdata[`SXSF_IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= '0;
            src_q   <= '0;
        end else begin
            istat_q <= istat_d;
            src_q   <= src_now;
        end
    end

    // Terminal link bits have no write path at all; they sample the terminal inputs each edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tl_comm_q <= 8'h00;
            tl_prio_q <= 8'h00;
        end else begin
            tl_comm_q <= operator_terminal_comm;
            tl_prio_q <= operator_terminal_prio;
        end
    end

endmodule

// ==== sxsf_top_sva.sv ====
// Port-level checks of the serial port status block
`timescale 1ns/1ps
`include "sxsf_defines.svh"
module sxsf_top_sva
    import sxsf_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [3:0]    pstrb,
    input wire logic          pready,
    input wire logic [31:0]   prdata,
    input wire logic          pslverr,
    input wire sxsf_port_ev_t ev_422,
    input wire sxsf_port_ev_t ev_232,
    input wire logic [7:0]    operator_terminal_comm,
    input wire logic [7:0]    operator_terminal_prio,
    input wire logic          irq
);
    wire logic [9:0] idx    = paddr[11:2];
    wire logic       setup  = psel && !penable;
    wire logic       ok_adr = paddr[1:0] == 2'h0 && idx inside {[`SXSF_IDX_422_STAT:`SXSF_IDX_422_CNT],
        [`SXSF_IDX_232_STAT:`SXSF_IDX_232_TLINK], [`SXSF_IDX_CTRL:`SXSF_IDX_IRQ_MASK]};
    wire logic       rd_ok  = setup && !pwrite && ok_adr;
    // Sticky events reach irq two edges later, a mask write one edge later
    wire logic       ev_any = ev_422.rx_done | ev_422.rx_ovf | (|ev_422.err) | ev_232.rx_done
        | ev_232.rx_ovf | (|ev_232.err);
    wire logic       msk_wr = psel && penable && pwrite && pstrb[0] && idx == `SXSF_IDX_IRQ_MASK;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_slverr; setup |=> pslverr == !$past(ok_adr); endproperty
    a_slverr: assert property (p_slverr) else $error("pslverr wrong");
    property p_hold; !setup |=> $stable(prdata) && $stable(pslverr); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_upper; rd_ok |=> prdata[31:16] == 16'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper half set");
    property p_cfg4; rd_ok && idx == `SXSF_IDX_422_STAT |=> prdata[15] == $past(ev_422.cfg_busy, 2); endproperty
    a_cfg4: assert property (p_cfg4) else $error("422 cfg busy wrong");
    property p_cfg2; rd_ok && idx == `SXSF_IDX_232_STAT |=> prdata[12] == $past(ev_232.cfg_busy, 2); endproperty
    a_cfg2: assert property (p_cfg2) else $error("232 cfg busy wrong");
    property p_errsum; rd_ok && idx == `SXSF_IDX_422_STAT |=> prdata[8] == |prdata[5:2]; endproperty
    a_errsum: assert property (p_errsum) else $error("422 error summary wrong");
    property p_tlink; rd_ok && idx == `SXSF_IDX_232_TLINK
        |=> prdata[15:0] == $past({operator_terminal_prio, operator_terminal_comm}, 2); endproperty
    a_tlink: assert property (p_tlink) else $error("terminal bits wrong");
    property p_irq; $rose(irq) |-> $past(ev_any, 2) || $past(msk_wr); endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
    cover property (rd_ok && idx == `SXSF_IDX_422_CNT ##1 prdata != 32'h0);
    cover property ($rose(irq));
    cover property (setup ##1 pslverr);
endmodule
bind sxsf_top sxsf_top_sva #(.CNT_W(CNT_W)) u_sva (.*);

// ==== sxsf_peer.sv ====
// Behavioural far side: serial port events and operator terminal levels
`timescale 1ns/1ps
module sxsf_peer
    import sxsf_pkg::*;
(
    input  wire logic     pclk,
    output sxsf_port_ev_t ev_422,
    output sxsf_port_ev_t ev_232,
    output logic [7:0]    operator_terminal_comm,
    output logic [7:0]    operator_terminal_prio
);
    sxsf_port_ev_t ev [2] = '{default: '0};
    logic [7:0]    c_q    = 8'h00;
    logic [7:0]    p_q    = 8'h00;
    assign ev_422 = ev[0];
    assign ev_232 = ev[1];
    assign operator_terminal_comm = c_q;
    assign operator_terminal_prio = p_q;
    // Completion rides on the last byte; gap makes a slow sender
    task automatic rx(input int p, input int n, input int gap);
        for (int i = 1; i <= n; i++) begin
            @(posedge pclk);
            ev[p].rx_byte <= 1'h1;
            ev[p].rx_done <= i == n;
            @(posedge pclk);
            ev[p].rx_byte <= 1'h0;
            ev[p].rx_done <= 1'h0;
            repeat (gap) @(posedge pclk);
        end
    endtask
    task automatic pulse(input int p, input logic ovf, input logic [3:0] err);
        @(posedge pclk);
        ev[p].rx_ovf <= ovf;
        ev[p].err <= err;
        @(posedge pclk);
        ev[p].rx_ovf <= 1'h0;
        ev[p].err <= 4'h0;
    endtask
    task automatic lvl(input int p, input logic tx, input logic cfg, input logic [7:0] c, input logic [7:0] pr);
        @(posedge pclk);
        ev[p].tx_ready <= tx;
        ev[p].cfg_busy <= cfg;
        c_q <= c;
        p_q <= pr;
    endtask
endmodule

// ==== serial_port_status_flags_bench.sv ====
// Self-checking bench of the serial port status block
`timescale 1ns/1ps
`include "sxsf_defines.svh"
module serial_port_status_flags_bench
    import sxsf_pkg::*;
;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata;
    logic [3:0]    pstrb;
    logic [7:0]    operator_terminal_comm, operator_terminal_prio;
    sxsf_port_ev_t ev_422, ev_232;
    int            n_mismatch = 0;
    int            samples_checked = 0;
    sxsf_top #(.CNT_W(16)) DUT (.*);
    sxsf_peer u_peer (.*);
    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One idle cycle before each setup lets level inputs settle into flags
    task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d,
                        input logic e_x = 1'h0, input logic [1:0] lo = 2'h0);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {i, lo};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 64);
        if (k == 64) begin
            n_mismatch++;
            test_done();
        end
        if (!w && !e_x) cmp("prdata", d, prdata);
        cmp("pslverr", {31'h0, e_x}, {31'h0, pslverr});
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    initial begin
        static logic [31:0] s4;
        // Order: 422 status, 422 count, 232 status, 232 count, terminal, ctrl, cmd, irq status, mask
        static logic [9:0] ro [9] = '{`SXSF_IDX_422_STAT, `SXSF_IDX_422_CNT, `SXSF_IDX_232_STAT, `SXSF_IDX_232_CNT,
            `SXSF_IDX_232_TLINK, `SXSF_IDX_CTRL, `SXSF_IDX_CMD, `SXSF_IDX_IRQ_STAT, `SXSF_IDX_IRQ_MASK};
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        foreach (ro[j]) xfer(1'h0, ro[j], 32'h0);
        xfer(1'h0, 10'h3ff, 32'h0, 1'h1);
        xfer(1'h1, ro[1], 32'h0, 1'h1, 2'h2);
        u_peer.rx(0, 4, 0);
        xfer(1'h0, ro[1], 32'h0);
        xfer(1'h1, ro[5], 32'h3);
        xfer(1'h1, ro[1], 32'h1234);
        xfer(1'h0, ro[5], 32'h3);
        u_peer.rx(0, 5, 0);
        xfer(1'h0, ro[1], 32'h5);
        xfer(1'h0, ro[0], 32'h400);
        u_peer.rx(1, 3, 3);
        xfer(1'h0, ro[3], 32'h3);
        xfer(1'h0, ro[2], 32'h40);
        u_peer.pulse(0, 1'h1, 4'h0);
        u_peer.pulse(1, 1'h1, 4'h0);
        xfer(1'h0, ro[0], 32'hc00);
        xfer(1'h0, ro[2], 32'hc0);
        s4 = 32'hd00;
        for (int b = 0; b < 4; b++) begin
            u_peer.pulse(0, 1'h0, 4'h1 << b);
            s4 |= 32'h4 << b;
            xfer(1'h0, ro[0], s4);
        end
        u_peer.pulse(1, 1'h0, 4'h2);
        xfer(1'h0, ro[2], 32'hd0);
        u_peer.lvl(0, 1'h1, 1'h1, 8'h00, 8'h00);
        u_peer.lvl(1, 1'h1, 1'h1, 8'h00, 8'h00);
        xfer(1'h0, ro[0], 32'h8f3c);
        xfer(1'h0, ro[2], 32'h10f0);
        xfer(1'h1, ro[5], 32'h1);
        xfer(1'h0, ro[2], 32'h10d0);
        xfer(1'h1, ro[5], 32'h3);
        u_peer.lvl(0, 1'h0, 1'h0, 8'h00, 8'h00);
        u_peer.lvl(1, 1'h0, 1'h0, 8'h00, 8'h00);
        xfer(1'h0, ro[0], 32'hd3c);
        xfer(1'h0, ro[2], 32'hd0);
        xfer(1'h0, ro[7], 32'h3f);
        cmp("irq", 32'h0, {31'h0, irq});
        xfer(1'h1, ro[8], 32'h8);
        @(negedge pclk);
        cmp("irq", 32'h1, {31'h0, irq});
        xfer(1'h1, ro[7], 32'h8);
        xfer(1'h0, ro[7], 32'h37);
        cmp("irq", 32'h0, {31'h0, irq});
        // Low strobe lane off: the control write must be ignored
        pstrb <= 4'he;
        xfer(1'h1, ro[5], 32'h0);
        pstrb <= 4'hf;
        xfer(1'h1, ro[6], 32'h3);
        foreach (ro[j]) if (j < 7) xfer(1'h0, ro[j], (j == 5) ? 32'h3 : 32'h0);
        for (int u = 0; u < 8; u++) begin
            u_peer.lvl(1, 1'h0, 1'h0, 8'h1 << u, 8'h80 >> u);
            xfer(1'h0, ro[4], {16'h0, 8'h80 >> u, 8'h1 << u});
        end
        test_done();
    end
endmodule
